/* File: design/flash_host_defs.svh */
// Constants for the parallel NOR flash status-polling controller.
// Assumes a 100 MHz clock and a 16-bit flash with 22 address bits.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define ADDR_W          22
`define DATA_W          16

// =====================================================================
// Timing
`define CLK_PERIOD_NS   10
`define RD_ACCESS_NS    70
`define WE_PULSE_NS     35
`define CYC_GAP_NS      20
`define SYNC_STAGES     2
`define RD_ACCESS_CYC   ((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_CYC    ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_GAP_CYC     ((`CYC_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_PULSE_CYC    (`RD_ACCESS_CYC + `SYNC_STAGES)

// =====================================================================
// Flash status bits and commands
`define POLLING_BIT     7
`define TOGGLE_BIT_ONE  6
`define TIMEOUT_FLAG    5
`define TOGGLE_BIT_TWO  2
`define RESET_CMD       16'h00F0

// =====================================================================
// Register map (byte offsets) and fields
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0C
`define REG_RDATA       8'h10
`define ST_BUSY         0
`define ST_DONE         1
`define ST_FAIL         2
`define ST_TIMEOUT      3
`define ST_TOG2         4

`endif

/* File: design/flash_host_pkg.sv */
// Types shared by the flash status-polling controller.
// Assumes the constants header is compiled alongside.
`default_nettype none
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_WRITE  = 3'h1,
    OP_READ   = 3'h2,
    OP_TOGGLE = 3'h3,
    OP_DATA   = 3'h4,
    OP_RESET  = 3'h5,
    OP_ABORT  = 3'h7
  } op_t;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_SINGLE = 7'h02,
    S_RD_A   = 7'h04,
    S_RD_B   = 7'h08,
    S_DPOLL  = 7'h10,
    S_FINAL  = 7'h20,
    S_RST    = 7'h40
  } ctrl_state_t;

  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_SETUP = 4'h2,
    C_PULSE = 4'h4,
    C_HOLD  = 4'h8
  } cyc_state_t;

endpackage
`default_nettype wire

/* File: design/flash_bus_cycle.sv */
// One flash bus cycle, read or write, on the chip select, output enable
// and write strobe pins. Assumes an asynchronous flash on the far side.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 start_i,
  input  wire logic                 write_i,
  input  wire logic [`ADDR_W-1:0]   addr_i,
  input  wire logic [`DATA_W-1:0]   wdata_i,
  output logic                      done_o,
  output logic [`DATA_W-1:0]        rdata_o,
  output logic                      ce_n_o,
  output logic                      oe_n_o,
  output logic                      we_n_o,
  output logic [`ADDR_W-1:0]        addr_o,
  output logic [`DATA_W-1:0]        dq_o,
  output logic                      dq_oe_o,
  input  wire logic [`DATA_W-1:0]   dq_i
);

  cyc_state_t           state, next_state;
  logic [3:0]           cnt, next_cnt;
  logic                 is_wr, next_is_wr;
  logic                 next_done, next_ce_n, next_oe_n, next_we_n, next_dq_oe;
  logic [`ADDR_W-1:0]   next_addr;
  logic [`DATA_W-1:0]   next_dq, next_rdata;
  logic [`DATA_W-1:0]   dq_s1, dq_s2;

  // =====================================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_is_wr = is_wr;
    next_done  = 1'b0;
    next_ce_n  = ce_n_o;
    next_oe_n  = oe_n_o;
    next_we_n  = we_n_o;
    next_dq_oe = dq_oe_o;
    next_addr  = addr_o;
    next_dq    = dq_o;
    next_rdata = rdata_o;
    unique case (state)
      C_IDLE: begin
        if (start_i) begin
          next_state = C_SETUP;
          next_is_wr = write_i;
          next_addr  = addr_i;
          next_dq    = wdata_i;
          next_dq_oe = write_i;
          next_ce_n  = 1'b0;
        end
      end
      C_SETUP: begin
        next_state = C_PULSE;
        next_oe_n  = is_wr;
        next_we_n  = !is_wr;
        next_cnt   = is_wr ? 4'(`WE_PULSE_CYC - 1) : 4'(`RD_PULSE_CYC - 1);
      end
      C_PULSE: begin
        if (cnt == 4'h0) begin
          // Write data latched by the flash on this strobe's rising edge
          next_state = C_HOLD;
          next_oe_n  = 1'b1;
          next_we_n  = 1'b1;
          next_cnt   = 4'(`CYC_GAP_CYC - 1);
          if (!is_wr) begin
            next_rdata = dq_s2;
            next_ce_n  = 1'b1;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      C_HOLD: begin
        // Every read ends with the strobes high, so the flash sees a fresh read cycle
        next_ce_n  = 1'b1;
        next_dq_oe = 1'b0;
        if (cnt == 4'h0) begin
          next_state = C_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
    if (rst_i) begin
      state   <= C_IDLE;
      cnt     <= 4'h0;
      is_wr   <= 1'b0;
      done_o  <= 1'b0;
      ce_n_o  <= 1'b1;
      oe_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      dq_oe_o <= 1'b0;
      addr_o  <= '0;
      dq_o    <= '0;
      rdata_o <= '0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      is_wr   <= next_is_wr;
      done_o  <= next_done;
      ce_n_o  <= next_ce_n;
      oe_n_o  <= next_oe_n;
      we_n_o  <= next_we_n;
      dq_oe_o <= next_dq_oe;
      addr_o  <= next_addr;
      dq_o    <= next_dq;
      rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: design/flash_host_ctrl.sv */
// Flash status-polling controller: software registers over classic
// Wishbone, flash pins driven through one bus-cycle engine.
// Assumes a parallel NOR flash on the pins and a Wishbone master.
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      flash_ce_n_o,
  output logic                      flash_oe_n_o,
  output logic                      flash_we_n_o,
  output logic [`ADDR_W-1:0]        flash_addr_o,
  output logic [`DATA_W-1:0]        flash_dq_o,
  output logic                      flash_dq_oe_o,
  input  wire logic [`DATA_W-1:0]   flash_dq_i
);

  ctrl_state_t          state, next_state;
  logic [`ADDR_W-1:0]   op_addr, next_op_addr;
  logic [`DATA_W-1:0]   op_wdata, next_op_wdata;
  logic [`DATA_W-1:0]   first_val, next_first_val;
  logic [`DATA_W-1:0]   rdata, next_rdata;
  logic                 recheck, next_recheck;
  logic                 done_f, next_done_f;
  logic                 fail_f, next_fail_f;
  logic                 tmo_f, next_tmo_f;
  logic                 tog2_f, next_tog2_f;
  logic                 cyc_start, next_cyc_start;
  logic                 cyc_we, next_cyc_we;
  logic [`ADDR_W-1:0]   cyc_addr, next_cyc_addr;
  logic [`DATA_W-1:0]   cyc_data, next_cyc_data;
  logic                 next_ack;
  logic [31:0]          next_dat_o;
  logic                 eng_done;
  logic [`DATA_W-1:0]   eng_rdata;
  logic                 bus_wr, ctrl_wr;
  op_t                  op;

  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign ctrl_wr = bus_wr && (wb_adr_i == `REG_CTRL) && wb_sel_i[0];
  assign op      = op_t'(wb_dat_i[2:0]);

  // =====================================================================
  // Bus-cycle engine
  flash_bus_cycle u_cycle (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (cyc_start),
    .write_i (cyc_we),
    .addr_i  (cyc_addr),
    .wdata_i (cyc_data),
    .done_o  (eng_done),
    .rdata_o (eng_rdata),
    .ce_n_o  (flash_ce_n_o),
    .oe_n_o  (flash_oe_n_o),
    .we_n_o  (flash_we_n_o),
    .addr_o  (flash_addr_o),
    .dq_o    (flash_dq_o),
    .dq_oe_o (flash_dq_oe_o),
    .dq_i    (flash_dq_i)
  );

  // =====================================================================
  // Next-state logic
  always_comb begin
    next_state     = state;
    next_op_addr   = op_addr;
    next_op_wdata  = op_wdata;
    next_first_val = first_val;
    next_rdata     = rdata;
    next_recheck   = recheck;
    next_done_f    = done_f;
    next_fail_f    = fail_f;
    next_tmo_f     = tmo_f;
    next_tog2_f    = tog2_f;
    next_cyc_start = 1'b0;
    next_cyc_we    = cyc_we;
    next_cyc_addr  = cyc_addr;
    next_cyc_data  = cyc_data;
    next_ack       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat_o     = 32'h0000_0000;

    // Register reads
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      unique case (wb_adr_i)
        `REG_ADDR:   next_dat_o = 32'(op_addr);
        `REG_WDATA:  next_dat_o = 32'(op_wdata);
        `REG_RDATA:  next_dat_o = 32'(rdata);
        `REG_STATUS: next_dat_o = 32'({tog2_f, tmo_f, fail_f, done_f, state != S_IDLE});
        default:     next_dat_o = 32'h0000_0000;
      endcase
    end

    // Parameter registers, byte lanes honoured, writable only while idle
    if (bus_wr && state == S_IDLE) begin
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b] && wb_adr_i == `REG_ADDR)
          next_op_addr[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
      if (wb_adr_i == `REG_ADDR && wb_sel_i[2])
        next_op_addr[`ADDR_W-1:16] = wb_dat_i[`ADDR_W-1:16];
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b] && wb_adr_i == `REG_WDATA)
          next_op_wdata[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end

    unique case (state)
      S_IDLE: begin
        if (ctrl_wr && op != OP_NONE && op != OP_ABORT) begin
          next_done_f    = 1'b0;
          next_fail_f    = 1'b0;
          next_tmo_f     = 1'b0;
          next_recheck   = 1'b0;
          next_cyc_start = 1'b1;
          next_cyc_addr  = op_addr;
          next_cyc_we    = (op == OP_WRITE) || (op == OP_RESET);
          next_cyc_data  = (op == OP_RESET) ? `RESET_CMD : op_wdata;
          unique case (op)
            OP_TOGGLE: next_state = S_RD_A;
            OP_DATA:   next_state = S_DPOLL;
            default:   next_state = S_SINGLE;
          endcase
        end
      end
      S_SINGLE: begin
        if (eng_done) begin
          if (!cyc_we)
            next_rdata = eng_rdata;
          next_done_f = 1'b1;
          next_state  = S_IDLE;
        end
      end
      S_RD_A: begin
        if (eng_done) begin
          next_first_val = eng_rdata;
          next_cyc_start = 1'b1;
          next_state     = S_RD_B;
        end
      end
      S_RD_B: begin
        if (eng_done) begin
          next_rdata  = eng_rdata;
          // A settled pair is array data, so bit five is no flag then
          next_tmo_f  = tmo_f | (eng_rdata[`TIMEOUT_FLAG] &&
                                 first_val[`TOGGLE_BIT_ONE] != eng_rdata[`TOGGLE_BIT_ONE]);
          next_tog2_f = first_val[`TOGGLE_BIT_TWO] ^ eng_rdata[`TOGGLE_BIT_TWO];
          if (first_val[`TOGGLE_BIT_ONE] == eng_rdata[`TOGGLE_BIT_ONE]) begin
            next_done_f = 1'b1;
            next_state  = S_IDLE;
          end else if (recheck) begin
            next_fail_f    = 1'b1;
            next_cyc_start = 1'b1;
            next_cyc_we    = 1'b1;
            next_cyc_data  = `RESET_CMD;
            next_state     = S_RST;
          end else begin
            // Timeout flag high: one more double read before giving up
            next_recheck   = eng_rdata[`TIMEOUT_FLAG];
            next_cyc_start = 1'b1;
            next_state     = S_RD_A;
          end
        end
      end
      S_DPOLL: begin
        if (eng_done) begin
          next_rdata = eng_rdata;
          next_tmo_f = tmo_f | (eng_rdata[`TIMEOUT_FLAG] &&
                                eng_rdata[`POLLING_BIT] != op_wdata[`POLLING_BIT]);
          next_cyc_start = 1'b1;
          if (eng_rdata[`POLLING_BIT] == op_wdata[`POLLING_BIT]) begin
            // Lower bits may still be status; take data from a later read
            next_state = S_FINAL;
          end else if (recheck) begin
            next_fail_f   = 1'b1;
            next_cyc_we   = 1'b1;
            next_cyc_data = `RESET_CMD;
            next_state    = S_RST;
          end else begin
            next_recheck = eng_rdata[`TIMEOUT_FLAG];
          end
        end
      end
      S_FINAL: begin
        if (eng_done) begin
          next_rdata  = eng_rdata;
          next_done_f = 1'b1;
          next_state  = S_IDLE;
        end
      end
      S_RST: begin
        if (eng_done) begin
          next_done_f = 1'b1;
          next_state  = S_IDLE;
        end
      end
    endcase

    // Abort lets the running cycle finish cleanly, then stops
    if (ctrl_wr && op == OP_ABORT && (state & (S_RD_A | S_RD_B | S_DPOLL | S_FINAL)) != 7'h00) begin
      // Engine already idle when its done pulse is here: no later pulse to wait for
      next_cyc_start = 1'b0;
      next_state     = eng_done ? S_IDLE : S_SINGLE;
      if (eng_done)
        next_done_f = 1'b1;
    end
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      op_addr   <= '0;
      op_wdata  <= '0;
      first_val <= '0;
      rdata     <= '0;
      recheck   <= 1'b0;
      done_f    <= 1'b0;
      fail_f    <= 1'b0;
      tmo_f     <= 1'b0;
      tog2_f    <= 1'b0;
      cyc_start <= 1'b0;
      cyc_we    <= 1'b0;
      cyc_addr  <= '0;
      cyc_data  <= '0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      op_addr   <= next_op_addr;
      op_wdata  <= next_op_wdata;
      first_val <= next_first_val;
      rdata     <= next_rdata;
      recheck   <= next_recheck;
      done_f    <= next_done_f;
      fail_f    <= next_fail_f;
      tmo_f     <= next_tmo_f;
      tog2_f    <= next_tog2_f;
      cyc_start <= next_cyc_start;
      cyc_we    <= next_cyc_we;
      cyc_addr  <= next_cyc_addr;
      cyc_data  <= next_cyc_data;
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_dat_o;
    end
  end

endmodule
`default_nettype wire

/* File: verification/flash_host_props.sv */
// Checker for the Wishbone side and the flash pins of the polling controller.
// Assumes one clock and a synchronous active-high reset; bound onto the top.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

module flash_host_props (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                flash_ce_n_o,
  input wire logic                flash_oe_n_o,
  input wire logic                flash_we_n_o,
  input wire logic [`ADDR_W-1:0]  flash_addr_o,
  input wire logic                flash_dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Register bus
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in the next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");

  // ==========================================================
  // Flash pins
  AST_OE_FRAMED: assert property (!flash_oe_n_o |-> !flash_ce_n_o)
    else $error("output enable low without chip select");
  AST_NO_CONTENTION: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
    else $error("controller drives data during a read");
  AST_WE_DRIVES: assert property (!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o)
    else $error("write strobe without data or select");
  AST_WE_PULSE: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o[*4] ##1 flash_we_n_o)
    else $error("write strobe not four cycles");
  AST_OE_PULSE: assert property ($fell(flash_oe_n_o) |-> ##8 !flash_oe_n_o ##1 flash_oe_n_o)
    else $error("read strobe not nine cycles");
  AST_ADDR_HELD: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved inside a cycle");
  AST_CYCLE_GAP: assert property ($rose(flash_ce_n_o) |-> flash_ce_n_o[*2])
    else $error("flash cycles closer than two cycles");
endmodule

bind flash_host_ctrl flash_host_props props_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o), .flash_addr_o(flash_addr_o),
  .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire

/* File: verification/flash_model.sv */
// Behavioural NOR flash giving status words during program and erase.
// Assumes the bench resolves the controller's split data pins into one bus.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

module flash_model (
  input  wire logic [`ADDR_W-1:0] addr_i,
  input  wire logic               ce_n_i,
  input  wire logic               oe_n_i,
  input  wire logic               we_n_i,
  input  wire logic [`DATA_W-1:0] dq_i,
  output logic      [`DATA_W-1:0] dq_o
);
  // Reads left before the operation ends; 0 is array mode
  int unsigned         busy_reads = 0;
  int unsigned         resets     = 0;
  logic                erase_op   = 1'b0;
  logic                tmo        = 1'b0;
  logic                tog_one    = 1'b0;
  logic                tog_two    = 1'b0;
  logic [`DATA_W-1:0]  mem        = 16'h0000;
  logic [`DATA_W-1:0]  last_out   = 16'h0000;
  logic [`DATA_W-1:0]  cur;
  logic [`ADDR_W-1:0]  wr_adr     = '0;
  logic [`ADDR_W-1:0]  rd_adr     = '0;
  wire                 rd_act     = !ce_n_i && !oe_n_i;
  wire                 wr_act     = !ce_n_i && !we_n_i;

  // Finite counts fall back to array read, as a protected target does
  task automatic start_op(input int unsigned n, input logic erase, input logic limit);
    busy_reads = n;
    erase_op   = erase;
    tmo        = limit;
  endtask

  always_comb begin
    cur = mem;
    if (busy_reads != 0) begin
      cur[7] = erase_op ? 1'b0 : ~mem[7];
      cur[6] = tog_one;
      cur[5] = tmo;
      if (erase_op) cur[2] = tog_two;
      if (busy_reads == 1 && !erase_op) cur[7] = mem[7];
    end
  end

  // Released bus shows the inverse so a stale word never matches
  assign dq_o = rd_act ? cur : ~last_out;

  always @(negedge rd_act) begin
    last_out <= cur;
    rd_adr   <= addr_i;
    if (busy_reads != 0) begin
      tog_one    <= ~tog_one;
      tog_two    <= erase_op ? ~tog_two : tog_two;
      busy_reads <= busy_reads - 1;
    end
  end

  always @(negedge wr_act) begin
    if (dq_i[7:0] == 8'hF0) begin
      busy_reads <= 0;
      tmo        <= 1'b0;
      resets     <= resets + 1;
    end else begin
      mem    <= dq_i;
      wr_adr <= addr_i;
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench: Wishbone tasks drive the polling controller
// against the behavioural flash; no random stimulus.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defs.svh"

module tb;
  logic                clk_i  = 1'b0;
  logic                rst_i  = 1'b1;
  logic                cyc    = 1'b0;
  logic                stb    = 1'b0;
  logic                we     = 1'b0;
  logic [7:0]          adr    = 8'h00;
  logic [31:0]         dat_w  = 32'h0;
  logic [31:0]         st;
  wire  [31:0]         dat_r;
  wire                 ack, ce_n, oe_n, we_n, dq_oe;
  wire  [`ADDR_W-1:0]  f_adr;
  wire  [`DATA_W-1:0]  f_dq, fm_dq, dq_bus;
  int                  mismatches = 0;
  int                  cmp_count  = 0;
  int                  exp_rst    = 0;

  assign dq_bus = dq_oe ? f_dq : fm_dq;

  flash_host_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(f_adr),
    .flash_dq_o(f_dq), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_bus));
  flash_model fm_u (.addr_i(f_adr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_bus), .dq_o(fm_dq));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, st);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, st);
    chk(nm, st, exp);
  endtask

  // Status is polled until busy drops; a hang ends after 500 polls and counts as a mismatch
  task automatic run_op(input logic [2:0] op);
    int n;
    n = 0;
    wr(`REG_CTRL, {29'h0, op});
    do begin
      wb(1'b0, `REG_STATUS, 32'h0, st);
      n++;
    end while (st[`ST_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) mismatches++;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("status_rst", `REG_STATUS, 32'h0);
    rdc("ctrl_reads0", `REG_CTRL, 32'h0);
    wr(`REG_ADDR, 32'hFFFF_FFFF);
    wr(8'h24, 32'h1234_5678);
    rdc("unmapped", 8'h24, 32'h0);
    rdc("addr_width", `REG_ADDR, 32'h003F_FFFF);
    wr(`REG_ADDR, 32'h0002_ABCD);
    wr(`REG_WDATA, 32'hFFFF_5A3C);
    rdc("wdata_width", `REG_WDATA, 32'h0000_5A3C);
    run_op(3'h1);
    chk("array_word", fm_u.mem, 32'h5A3C);
    chk("array_adr", fm_u.wr_adr, 32'h2ABCD);
    run_op(3'h2);
    rdc("single_read", `REG_RDATA, 32'h5A3C);
    fm_u.start_op(5, 1'b0, 1'b0);
    run_op(3'h4);
    chk("dpoll_status", {28'h0, st[3:0]}, 32'h2);
    rdc("dpoll_data", `REG_RDATA, 32'h5A3C);
    chk("dpoll_adr", fm_u.rd_adr, 32'h2ABCD);
    fm_u.start_op(6, 1'b0, 1'b0);
    run_op(3'h3);
    chk("tpoll_status", {28'h0, st[3:0]}, 32'h2);
    fm_u.start_op(32'hFFFF_FFFF, 1'b1, 1'b0);
    wr(`REG_CTRL, 32'h3);
    repeat (100) @(posedge clk_i);
    wr(`REG_ADDR, 32'h1);
    run_op(3'h7);
    chk("abort_status", {27'h0, st[4:0]}, 32'h12);
    rdc("busy_write", `REG_ADDR, 32'h0002_ABCD);
    fm_u.busy_reads = 3;
    fm_u.tog_one    = 1'b0;
    run_op(3'h3);
    chk("restart_status", {28'h0, st[3:0]}, 32'h2);
    fm_u.start_op(32'hFFFF_FFFF, 1'b0, 1'b1);
    run_op(3'h3);
    exp_rst++;
    chk("tfail_status", {28'h0, st[3:0]}, 32'hE);
    chk("tfail_reset", fm_u.resets, exp_rst);
    chk("tfail_array", fm_u.busy_reads, 32'h0);
    wr(`REG_WDATA, 32'h0000_5ABC);
    fm_u.start_op(32'hFFFF_FFFF, 1'b1, 1'b1);
    run_op(3'h4);
    exp_rst++;
    chk("dfail_status", {28'h0, st[3:0]}, 32'hE);
    chk("dfail_reset", fm_u.resets, exp_rst);
    wr(`REG_WDATA, 32'h0000_5A3C);
    fm_u.start_op(1, 1'b0, 1'b1);
    run_op(3'h4);
    chk("late_done", {30'h0, st[2:1]}, 32'h1);
    fm_u.start_op(32'hFFFF_FFFF, 1'b0, 1'b1);
    run_op(3'h5);
    exp_rst++;
    chk("reset_cmd", fm_u.resets, exp_rst);
    chk("reset_array", fm_u.busy_reads, 32'h0);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
